// [core/fault_status_pkg.sv]
`default_nettype none
package fault_status_pkg;

  // command codes
  localparam logic [7:0] CMD_FAULT_SUMMARY_WORD   = 8'h79;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_FLAGS = 8'h7A;

  // summary word field positions
  localparam int SW_OUTPUT_VOLTAGE = 15;
  localparam int SW_OUTPUT_CURRENT = 14;
  localparam int SW_INPUT          = 13;
  localparam int SW_VENDOR         = 12;
  localparam int SW_POWER_GOOD     = 11;
  localparam int SW_UNSUP_HI       = 10;
  localparam int SW_OTHER          = 9;
  localparam int SW_UNSUP_LO       = 8;

  // summary byte field positions
  localparam int SB_BUSY     = 7;
  localparam int SB_OFF      = 6;
  localparam int SB_OUT_OV   = 5;
  localparam int SB_OUT_OC   = 4;
  localparam int SB_VIN_UV   = 3;
  localparam int SB_TEMP     = 2;
  localparam int SB_COMM     = 1;
  localparam int SB_NONE     = 0;

  // output-voltage flag positions
  localparam int OV_OVF  = 7;
  localparam int OV_OVW  = 6;
  localparam int OV_UVW  = 5;
  localparam int OV_UVF  = 4;
  localparam int OV_LIM  = 3;
  localparam int OV_TON  = 2;

  // write values with clearing side effects
  localparam logic [15:0] CLR_BUSY_VALUE         = 16'h0080;
  localparam logic [15:0] CLR_BUSY_UNRECOGNISED_CMD_FLAG_VALUE = 16'h0180;

  // reset values and supported masks
  localparam logic [7:0]  OV_FLAGS_RESET   = 8'h00;
  localparam logic [7:0]  OV_SUPPORTED     = 8'hFC;
  localparam logic [7:0]  MASK_RESET       = 8'h00;
  localparam logic [15:0] SUMMARY_RESET    = 16'h0000;
  localparam logic [15:0] SUMMARY_RO_MASK  = 16'hFA00;

  // fault event strobes from the converter core
  typedef struct packed {
    logic ov_fault;
    logic ov_warn;
    logic uv_warn;
    logic uv_fault;
    logic limit_violation;
    logic turn_on_timeout;
  } volt_event_type;

  // command port from the bus engine
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  cmd;
    logic [15:0] data;
  } cmd_req_type;

endpackage
`default_nettype wire

// [core/flag_latch.sv]
`timescale 1ns/1ps
`default_nettype none
module flag_latch #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             enable,
  // control
  input  wire logic [WIDTH-1:0] supported,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clear_in,
  // state
  output logic      [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_d;
  logic [WIDTH-1:0] flags_q;

  // set wins over a clear in the same cycle
  always_comb
  begin
    flags_d = ((flags_q & ~clear_in) | set_in) & supported;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      flags_q <= '0;
    else if (enable)
      flags_q <= flags_d;
  end

  assign flags = flags_q;
endmodule
`default_nettype wire

// [core/fault_summary_status_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module fault_summary_status_regs
(
  // clock and reset
  input  wire logic                            clock,
  input  wire logic                            nrst,
  input  wire logic                            clock_en,
  // command port from the bus engine
  input  wire fault_status_pkg::cmd_req_type   req,
  input  wire logic                            clear_faults,
  output logic      [15:0]                     rd_data,
  output logic                                 rd_hit,
  // fault events and detailed flags
  input  wire fault_status_pkg::volt_event_type volt_event,
  input  wire logic                            busy_event,
  input  wire logic                            unrecognised_cmd_flag_event,
  input  wire logic [7:0]                      output_current_flags,
  input  wire logic [7:0]                      input_flags,
  input  wire logic [7:0]                      vendor_flags,
  input  wire logic [7:0]                      other_flags,
  input  wire logic [7:0]                      summary_live_low,
  input  wire logic                            power_good_pin,
  // alert masks, alert output and status flag outputs
  input  wire logic [7:0]                      alert_mask_reg,
  input  wire logic [2:0]                      alert_mask_ext_reg,
  input  wire logic [2:0]                      ov_source,
  output logic                                 alert_request,
  output logic                                 unrecognised_cmd_flag,
  output logic      [7:0]                      output_voltage_flags
);
  import fault_status_pkg::*;

  logic [7:0]  ov_set;
  logic [7:0]  ov_clr;
  logic [7:0]  ov_flags;
  logic        busy_d;
  logic        busy_q;
  logic        unk_d;
  logic        unk_q;
  logic [2:0]  pg_sync_q;
  logic        pg_d;
  logic        pg_q;
  logic [15:0] rd_d;
  logic [15:0] rd_q;
  logic        hit_d;
  logic        hit_q;
  logic [15:0] summary;
  logic        wr_word;
  logic        wr_volt;
  logic        ovf_alert;

  function automatic logic any_set(input logic [7:0] v);
    any_set = |v;
  endfunction

  assign wr_word = req.wr && (req.cmd == CMD_FAULT_SUMMARY_WORD);
  assign wr_volt = req.wr && (req.cmd == CMD_OUTPUT_VOLTAGE_FLAGS);

  // events latch into the output-voltage flags
  always_comb
  begin
    ov_set         = '0;
    ov_set[OV_OVF] = volt_event.ov_fault;
    ov_set[OV_OVW] = volt_event.ov_warn;
    ov_set[OV_UVW] = volt_event.uv_warn;
    ov_set[OV_UVF] = volt_event.uv_fault;
    ov_set[OV_LIM] = volt_event.limit_violation;
    ov_set[OV_TON] = volt_event.turn_on_timeout;
    ov_clr         = clear_faults ? 8'hFF : (wr_volt ? req.data[7:0] : 8'h00);
  end

  flag_latch #(
    .WIDTH (8)
  ) u_output_voltage_summary_flags (
    .clock     (clock),
    .nrst      (nrst),
    .enable    (clock_en),
    .supported (OV_SUPPORTED),
    .set_in    (ov_set),
    .clear_in  (ov_clr),
    .flags     (ov_flags)
  );

  // busy and unrecognised_cmd_flag: events win over clears
  always_comb
  begin
    busy_d = busy_q;
    unk_d  = unk_q;
    if (clear_faults)
    begin
      busy_d = 1'b0;
      unk_d  = 1'b0;
    end
    else if (wr_word && (req.data == CLR_BUSY_VALUE))
      busy_d = 1'b0;
    else if (wr_word && (req.data == CLR_BUSY_UNRECOGNISED_CMD_FLAG_VALUE))
    begin
      busy_d = 1'b0;
      unk_d  = 1'b0;
    end
    if (busy_event)
      busy_d = 1'b1;
    if (unrecognised_cmd_flag_event)
      unk_d = 1'b1;
  end

  // power-good pin: three stages, change taken when last two agree
  always_comb
  begin
    pg_d = (pg_sync_q[2] == pg_sync_q[1]) ? pg_sync_q[2] : pg_q;
  end

  // summary word assembly; other writes touch nothing directly
  always_comb
  begin
    summary                    = SUMMARY_RESET;
    summary[7:0]               = summary_live_low & ~(8'h80 | (8'h01 << SB_OUT_OV));
    summary[SB_BUSY]           = busy_q;
    summary[SB_OUT_OV]         = ov_flags[OV_OVF];
    summary[SW_OUTPUT_VOLTAGE] = any_set(ov_flags);
    summary[SW_OUTPUT_CURRENT] = any_set(output_current_flags);
    summary[SW_INPUT]          = any_set(input_flags);
    summary[SW_VENDOR]         = any_set(vendor_flags);
    summary[SW_POWER_GOOD]     = pg_q;
    summary[SW_OTHER]          = any_set(other_flags);
    summary[SW_UNSUP_HI]       = 1'b0;
    summary[SW_UNSUP_LO]       = 1'b0;
  end

  // read data registered one cycle after the request
  always_comb
  begin
    rd_d  = rd_q;
    hit_d = 1'b0;
    if (req.rd)
    begin
      case (req.cmd)
        CMD_FAULT_SUMMARY_WORD:
        begin
          rd_d  = summary;
          hit_d = 1'b1;
        end
        CMD_OUTPUT_VOLTAGE_FLAGS:
        begin
          rd_d  = {8'h00, ov_flags};
          hit_d = 1'b1;
        end
        default:
        begin
          rd_d  = 16'h0000;
          hit_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_q    <= 1'b0;
      unk_q     <= 1'b0;
      pg_sync_q <= 3'b000;
      pg_q      <= 1'b0;
      rd_q      <= SUMMARY_RESET;
      hit_q     <= 1'b0;
    end
    else if (clock_en)
    begin
      busy_q    <= busy_d;
      unk_q     <= unk_d;
      pg_sync_q <= {pg_sync_q[1:0], power_good_pin};
      pg_q      <= pg_d;
      rd_q      <= rd_d;
      hit_q     <= hit_d;
    end
  end

  // alert gating: ovf masked as one, extended mask per source
  always_comb
  begin
    ovf_alert     = |(ov_source & ~alert_mask_ext_reg) && ov_flags[OV_OVF];
    alert_request = (ovf_alert && !alert_mask_reg[OV_OVF])
                  | any_set(ov_flags & ~alert_mask_reg & ~(8'h01 << OV_OVF));
  end

  assign rd_data               = rd_q;
  assign rd_hit                = hit_q;
  assign unrecognised_cmd_flag = unk_q;
  assign output_voltage_flags  = ov_flags;

  // assertions
  property p_unsup_zero;
    @(posedge clock) disable iff (!nrst)
    hit_q |-> (rd_q[SW_UNSUP_HI] == 1'b0 && rd_q[SW_UNSUP_LO] == 1'b0);
  endproperty
  a_unsup_zero: assert property (p_unsup_zero) else $error("unsupported summary bit set");

  property p_ovf_latch;
    @(posedge clock) disable iff (!nrst)
    (clock_en && volt_event.ov_fault) |=> ov_flags[OV_OVF];
  endproperty
  a_ovf_latch: assert property (p_ovf_latch) else $error("overvoltage fault not latched");

  property p_low_zero;
    @(posedge clock) disable iff (!nrst)
    ov_flags[1:0] == 2'b00;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("unsupported flag bits set");

  property p_w1c;
    @(posedge clock) disable iff (!nrst)
    (clock_en && wr_volt && !clear_faults && req.data[OV_UVF] && !volt_event.uv_fault)
      |=> !ov_flags[OV_UVF];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_hold;
    @(posedge clock) disable iff (!nrst)
    (clock_en && ov_flags[OV_TON] && !clear_faults && !(wr_volt && req.data[OV_TON]))
      |=> ov_flags[OV_TON];
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without clear");

  property p_busy_clr;
    @(posedge clock) disable iff (!nrst)
    (clock_en && wr_word && req.data == CLR_BUSY_UNRECOGNISED_CMD_FLAG_VALUE && !busy_event && !unrecognised_cmd_flag_event)
      |=> (!busy_q && !unk_q);
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("0180h did not clear");

  property p_busy_set;
    @(posedge clock) disable iff (!nrst)
    (clock_en && busy_event) |=> busy_q;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set");

  property p_volt_sum;
    @(posedge clock) disable iff (!nrst)
    (clock_en && req.rd && req.cmd == CMD_FAULT_SUMMARY_WORD)
      |=> rd_q[SW_OUTPUT_VOLTAGE] == (|$past(ov_flags));
  endproperty
  a_volt_sum: assert property (p_volt_sum) else $error("voltage summary mismatch");

  property p_busy_only;
    @(posedge clock) disable iff (!nrst)
    (clock_en && wr_word && req.data == CLR_BUSY_VALUE && !clear_faults && !busy_event
      && !unrecognised_cmd_flag_event) |=> (!busy_q && unk_q == $past(unk_q));
  endproperty
  a_busy_only: assert property (p_busy_only) else $error("0080h cleared too much");

  property p_pg_live;
    @(posedge clock) disable iff (!nrst)
    (clock_en && pg_sync_q[2] == pg_sync_q[1]) |=> pg_q == $past(pg_sync_q[2]);
  endproperty
  a_pg_live: assert property (p_pg_live) else $error("power-good bit stale");

  property p_warn_alert;
    @(posedge clock) disable iff (!nrst)
    (ov_flags[OV_OVW] && !alert_mask_reg[OV_OVW]) |-> alert_request;
  endproperty
  a_warn_alert: assert property (p_warn_alert) else $error("warning silent");
endmodule
`default_nettype wire

// [verification/pmbus_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model
  import fault_status_pkg::*;
(
  // bus side
  input  wire logic                        clock,
  input  wire logic [15:0]                 rd_data,
  input  wire logic                        rd_hit,
  output var  fault_status_pkg::cmd_req_type req
);
  initial req = '0;
  // idle cycles model a slow host; released fields show junk
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      input int idle, output logic [15:0] q, output logic h);
    repeat (idle) @(posedge clock);
    @(posedge clock);
    #2 req = '{wr: w, rd: !w, cmd: c, data: d};
    @(posedge clock);
    #2 req = '{wr: 1'b0, rd: 1'b0, cmd: ~c, data: ~d};
    q = rd_data;
    h = rd_hit;
  endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fault_status_pkg::*;
  logic           clock, nrst, clock_en, clear_faults, busy_event, unrecognised_cmd_flag_event;
  logic           power_good_pin, rd_hit, h, alert_request, unrecognised_cmd_flag;
  cmd_req_type    req;
  volt_event_type volt_event;
  logic [7:0]     alert_mask_reg;
  logic [2:0]     alert_mask_ext_reg, ov_source;
  logic [7:0]     output_current_flags, input_flags, vendor_flags, other_flags;
  logic [7:0]     summary_live_low, output_voltage_flags;
  logic [15:0]    rd_data, q;
  int             mismatches, comparisons;

  fault_summary_status_regs dut_u (.clock, .nrst, .clock_en, .req, .clear_faults,
    .rd_data, .rd_hit, .volt_event, .busy_event, .unrecognised_cmd_flag_event,
    .output_current_flags, .input_flags, .vendor_flags, .other_flags,
    .summary_live_low, .power_good_pin, .alert_mask_reg,
    .alert_mask_ext_reg, .ov_source, .alert_request,
    .unrecognised_cmd_flag, .output_voltage_flags);
  pmbus_host_model host_u (.clock, .rd_data, .rd_hit, .req);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick;
    @(posedge clock);
    #2;
  endtask
  task automatic rd(input logic [7:0] c);
    host_u.xfer(1'b0, c, 16'h0000, 0, q, h);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int idle);
    host_u.xfer(1'b1, c, d, idle, q, h);
  endtask

  task automatic t_reset;
    rd(CMD_FAULT_SUMMARY_WORD);
    check({15'h0, h}, 16'h0001);
    check(q, 16'h0000);
    rd(CMD_OUTPUT_VOLTAGE_FLAGS);
    check(q, 16'h0000);
    rd(8'h7B);
    check({q[14:0], h}, 16'h0000);
  endtask

  task automatic t_volt;
    // frozen core must not latch
    tick;
    clock_en = 1'b0;
    volt_event = '1;
    tick;
    volt_event = '0;
    clock_en = 1'b1;
    rd(CMD_OUTPUT_VOLTAGE_FLAGS);
    check({8'h00, q[7:0]}, 16'h0000);
    for (int i = 2; i < 8; i++)
    begin
      tick;
      volt_event = 6'h01 << (i - 2);
      tick;
      volt_event = '0;
      rd(CMD_OUTPUT_VOLTAGE_FLAGS);
      check({8'h00, q[7:0]}, 16'h0001 << i);
      check({8'h00, output_voltage_flags}, 16'h0001 << i);
      wr(CMD_OUTPUT_VOLTAGE_FLAGS, {8'h00, ~(8'h01 << i)}, 1);
      rd(CMD_OUTPUT_VOLTAGE_FLAGS);
      check({8'h00, q[7:0]}, 16'h0001 << i);
      wr(CMD_OUTPUT_VOLTAGE_FLAGS, 16'h0001 << i, 0);
      rd(CMD_OUTPUT_VOLTAGE_FLAGS);
      check({8'h00, q[7:0]}, 16'h0000);
    end
    tick;
    volt_event = '1;
    tick;
    volt_event = '0;
    wr(CMD_OUTPUT_VOLTAGE_FLAGS, 16'h0003, 0);
    rd(CMD_OUTPUT_VOLTAGE_FLAGS);
    check({8'h00, q[7:0]}, 16'h00FC);
    rd(CMD_FAULT_SUMMARY_WORD);
    check(q, 16'h8020);
    clear_faults = 1'b1;
    tick;
    clear_faults = 1'b0;
    rd(CMD_OUTPUT_VOLTAGE_FLAGS);
    check({8'h00, q[7:0]}, 16'h0000);
    rd(CMD_FAULT_SUMMARY_WORD);
    check(q, 16'h0000);
  endtask

  task automatic t_summary;
    logic [15:0] exp [4] = '{16'h4000, 16'h2000, 16'h1000, 16'h0200};
    for (int k = 0; k < 4; k++)
    begin
      {output_current_flags, input_flags, vendor_flags, other_flags} = 32'h80 << (8 * (3 - k));
      rd(CMD_FAULT_SUMMARY_WORD);
      check(q, exp[k]);
    end
    {output_current_flags, input_flags, vendor_flags, other_flags} = '0;
    summary_live_low = 8'hFF;
    wr(CMD_FAULT_SUMMARY_WORD, 16'hFFFF, 0);
    rd(CMD_FAULT_SUMMARY_WORD);
    check(q, 16'h005F);
    summary_live_low = 8'h00;
    power_good_pin = 1'b1;
    // pin is synchronised, so poll a bounded number of reads
    for (int n = 0; n < 8 && q[SW_POWER_GOOD] !== 1'b1; n++)
      rd(CMD_FAULT_SUMMARY_WORD);
    check(q, 16'h0800);
    power_good_pin = 1'b0;
    // bit must also fall back before later scenarios read the word
    for (int n = 0; n < 8 && q[SW_POWER_GOOD] !== 1'b0; n++)
      rd(CMD_FAULT_SUMMARY_WORD);
    check(q, 16'h0000);
  endtask

  task automatic t_busy;
    for (int j = 0; j < 2; j++)
    begin
      tick;
      busy_event = 1'b1;
      unrecognised_cmd_flag_event = (j == 0);
      tick;
      {busy_event, unrecognised_cmd_flag_event} = 2'b00;
      rd(CMD_FAULT_SUMMARY_WORD);
      check(q, 16'h0080);
      wr(CMD_FAULT_SUMMARY_WORD, j == 0 ? CLR_BUSY_VALUE : CLR_BUSY_UNRECOGNISED_CMD_FLAG_VALUE, 0);
      rd(CMD_FAULT_SUMMARY_WORD);
      check(q, 16'h0000);
      check({15'h0, unrecognised_cmd_flag}, j == 0 ? 16'h0001 : 16'h0000);
    end
  endtask

  task automatic t_alert;
    tick;
    volt_event = 6'h10;
    tick;
    volt_event = '0;
    tick;
    check({8'h00, output_voltage_flags}, 16'h0040);
    check({15'h0, alert_request}, 16'h0001);
    alert_mask_reg = 8'h40;
    tick;
    check({15'h0, alert_request}, 16'h0000);
    wr(CMD_OUTPUT_VOLTAGE_FLAGS, 16'h0040, 0);
    alert_mask_reg = 8'h00;
    ov_source = 3'h1;
    volt_event = 6'h20;
    tick;
    volt_event = '0;
    tick;
    check({8'h00, output_voltage_flags}, 16'h0080);
    check({15'h0, alert_request}, 16'h0001);
    alert_mask_reg = 8'h80;
    tick;
    check({15'h0, alert_request}, 16'h0000);
    alert_mask_reg = 8'h00;
    alert_mask_ext_reg = 3'h1;
    tick;
    check({15'h0, alert_request}, 16'h0000);
    alert_mask_ext_reg = 3'h2;
    tick;
    check({15'h0, alert_request}, 16'h0001);
    {busy_event, unrecognised_cmd_flag_event} = 2'b11;
    tick;
    {busy_event, unrecognised_cmd_flag_event} = 2'b00;
    clear_faults = 1'b1;
    tick;
    clear_faults = 1'b0;
    check({15'h0, unrecognised_cmd_flag}, 16'h0000);
    check({15'h0, alert_request}, 16'h0000);
    rd(CMD_FAULT_SUMMARY_WORD);
    check(q, 16'h0000);
    // async reset in mid-run must drop latched flags at once
    volt_event = 6'h01;
    tick;
    volt_event = '0;
    tick;
    check({8'h00, output_voltage_flags}, 16'h0004);
    nrst = 1'b0;
    #1;
    check({8'h00, output_voltage_flags}, 16'h0000);
    tick;
    nrst = 1'b1;
    rd(CMD_OUTPUT_VOLTAGE_FLAGS);
    check({15'h0, h}, 16'h0001);
    check(q, 16'h0000);
  endtask

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    {nrst, clear_faults, busy_event, unrecognised_cmd_flag_event, power_good_pin} = '0;
    clock_en = 1'b1;
    volt_event = '0;
    alert_mask_reg = 8'h00;
    {alert_mask_ext_reg, ov_source} = 6'h00;
    {output_current_flags, input_flags, vendor_flags, other_flags} = '0;
    summary_live_low = 8'h00;
    repeat (10) @(posedge clock);
    #2 nrst = 1'b1;
    t_reset;
    t_volt;
    t_summary;
    t_busy;
    t_alert;
    tally_and_finish;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
